// File: inc/wcs_pkg.sv
// word clock sync unit: shared constants, register map and types
// assumes a 50 MHz reference clock and a 32-bit apb register bus
`default_nettype none
package wcs_pkg;
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned RATE_HZ [8]   = '{32000, 44100, 48000, 64000, 88200, 96000, 176400, 192000};
    localparam logic [2:0]  IDX_DOUBLE    = 3'h3;
    localparam logic [2:0]  IDX_QUAD      = 3'h6;
    localparam logic [2:0]  IDX_RESET     = 3'h2;
    localparam logic [1:0]  SPD_SINGLE    = 2'h0;
    localparam logic [1:0]  SPD_DOUBLE    = 2'h1;
    localparam logic [1:0]  SPD_QUAD      = 2'h2;
    // loss of reference: no edge for this long
    localparam int unsigned LOSS_TIME_US  = 40;
    localparam int unsigned LOSS_CYC      = LOSS_TIME_US * (CLK_HZ / 1_000_000);
    localparam int          PER_W         = 12;
    localparam logic [PER_W-1:0] LOSS_CNT = PER_W'(LOSS_CYC);
    localparam logic [2:0]  LOCK_EDGES    = 3'h4;
    localparam int          TOL_SHIFT     = 5;
    localparam int          NCO_W         = 32;
    localparam int          HR_SHIFT      = 9;
    localparam logic [NCO_W-1:0] NCO_PHASE_EDGE = 32'h8000_0000;
    // register map
    localparam int          ADDR_W        = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_PERIOD   = 8'h10;
    localparam int          IRQ_W         = 2;
    localparam int          IRQ_LOCK      = 0;
    localparam int          IRQ_LOSS      = 1;

    typedef struct packed {
        logic [2:0] master_rate;
        logic       term_en;
        logic       single_speed;
        logic       src_word;
    } wcs_ctrl_t;
    localparam wcs_ctrl_t CTRL_RESET = '{master_rate: IDX_RESET, default: 1'b0};

    typedef struct packed {
        logic [1:0] spd_class;
        logic [2:0] cur_rate;
        logic [2:0] det_rate;
        logic       fallback;
        logic       sync;
        logic       lock;
    } wcs_status_t;

    function automatic logic [NCO_W-1:0] rate_inc(input logic [2:0] idx);
        return NCO_W'((64'(RATE_HZ[idx]) << NCO_W) / 64'(CLK_HZ));
    endfunction

    function automatic logic [PER_W-1:0] rate_per(input logic [2:0] idx);
        return PER_W'(CLK_HZ / RATE_HZ[idx]);
    endfunction

    function automatic logic [1:0] spd_of(input logic [2:0] idx);
        return (idx >= IDX_QUAD) ? SPD_QUAD : (idx >= IDX_DOUBLE) ? SPD_DOUBLE : SPD_SINGLE;
    endfunction

    // same-family single speed rate: 64k->32k, 88.2k/176.4k->44.1k, 96k/192k->48k
    function automatic logic [2:0] single_of(input logic [2:0] idx);
        case (idx)
            3'h3:    return 3'h0;
            3'h4:    return 3'h1;
            3'h6:    return 3'h1;
            3'h5:    return 3'h2;
            3'h7:    return 3'h2;
            default: return idx;
        endcase
    endfunction
endpackage
`default_nettype wire

// File: hw/wcs_nco.sv
// word clock sync unit: phase accumulator clock generator
// assumes a single clock domain; load realigns the phase at once
`default_nettype none
module wcs_nco
    import wcs_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    input  wire logic [NCO_W-1:0] inc,
    input  wire logic             load,
    output logic                  clk_out
);
    logic [NCO_W-1:0] phase_q;
    logic [NCO_W-1:0] phase_d;

    assign phase_d = load ? NCO_PHASE_EDGE : NCO_W'(phase_q + inc);
    assign clk_out = phase_q[NCO_W-1];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= '0;
        end else if (clk_en) begin
            phase_q <= phase_d;
        end
    end
endmodule // wcs_nco
`default_nettype wire

// File: hw/wcs_top.sv
// word clock sync unit: input detection, lock status, output generation, apb registers
// assumes wc_in is asynchronous to ref_clk; apb master on ref_clk
//
// Added by the designer: the register offsets and register access over APB.
`default_nettype none
// Summary of operation
// - use word input only when selected and valid
// - accept single, double, quad rates automatically
// - lock lamp and status on valid input
// - word clock output always driven
// - master output follows software rate
// - slave output equals input frequency
// - on loss fall back to nearest rate
// - single speed option divides output down
// - refreshed output edges aligned with input
// - selectable 75 ohm input termination
// - derive high rate clock from word clock
// - three speed classes of standard rates
module wcs_top
    import wcs_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              wc_in,
    output logic                   wc_out,
    output logic                   hr_clk,
    output logic                   term_en,
    output logic                   ref_lock_lamp,
    output logic                   irq
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HUNT = 3'b010,
        ST_LOCK = 3'b100
    } wcs_state_t;

    wcs_state_t        state_q;
    wcs_state_t        state_d;
    wcs_ctrl_t         ctrl_q;
    logic [IRQ_W-1:0]  irq_stat_q;
    logic [IRQ_W-1:0]  irq_mask_q;
    logic              wc_s1_q;
    logic              wc_s2_q;
    logic              wc_s3_q;
    logic [PER_W-1:0]  cnt_q;
    logic [PER_W-1:0]  per_q;
    logic [2:0]        cand_q;
    logic [2:0]        match_q;
    logic [2:0]        det_q;
    logic              fallback_q;
    logic [1:0]        div_cnt_q;
    logic [31:0]       prdata_q;
    logic              pslverr_q;

    // synchronised input and edge detect
    logic wc_edge;
    assign wc_edge = wc_s2_q & ~wc_s3_q;

    // period classification against nominal periods with tolerance
    logic       cls_hit;
    logic [2:0] cls_idx;
    always_comb begin
        logic [PER_W-1:0] nom;
        logic [PER_W-1:0] diff;
        nom     = '0;
        diff    = '0;
        cls_hit = 1'b0;
        cls_idx = '0;
        for (int i = 0; i < 8; i++) begin
            nom  = rate_per(3'(i));
            diff = (cnt_q > nom) ? PER_W'(cnt_q - nom) : PER_W'(nom - cnt_q);
            if (diff <= (nom >> TOL_SHIFT)) begin
                cls_hit = 1'b1;
                cls_idx = 3'(i);
            end
        end
    end

    logic timeout;
    logic same_cls;
    logic locked;
    assign timeout  = (cnt_q >= LOSS_CNT);
    assign same_cls = cls_hit && (cls_idx == cand_q);
    assign locked   = (state_q == ST_LOCK);

    // lock state machine
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (wc_edge) begin
                    state_d = ST_HUNT;
                end
            end
            ST_HUNT: begin
                if (timeout) begin
                    state_d = ST_IDLE;
                end else if (wc_edge && same_cls && (match_q == LOCK_EDGES - 3'h1)) begin
                    state_d = ST_LOCK;
                end
            end
            ST_LOCK: begin
                if (timeout || (wc_edge && !same_cls)) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // clock source selection
    logic       slave;
    logic [2:0] cur_idx;
    logic [2:0] out_idx;
    logic [1:0] div_max;
    logic       align;
    assign slave   = ctrl_q.src_word & locked;
    assign cur_idx = slave      ? det_q :
                     fallback_q ? det_q :
                     ctrl_q.master_rate;
    assign out_idx = ctrl_q.single_speed ? single_of(cur_idx) : cur_idx;
    assign div_max = !ctrl_q.single_speed ? 2'h0 :
                     (spd_of(cur_idx) == SPD_QUAD) ? 2'h3 :
                     (spd_of(cur_idx) == SPD_DOUBLE) ? 2'h1 : 2'h0;
    // a divider count left over from single speed must not skip an edge once division is off
    assign align   = slave & wc_edge & ((div_cnt_q == 2'h0) | (div_max == 2'h0));

    logic [NCO_W-1:0] wc_inc;
    logic [NCO_W-1:0] hr_inc;
    assign wc_inc = rate_inc(out_idx);
    assign hr_inc = rate_inc(single_of(cur_idx)) << HR_SHIFT;

    wcs_nco u_wc_nco (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .inc     (wc_inc),
        .load    (align),
        .clk_out (wc_out)
    );

    wcs_nco u_hr_nco (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .inc     (hr_inc),
        .load    (align),
        .clk_out (hr_clk)
    );

    // events
    logic [IRQ_W-1:0] evt;
    assign evt[IRQ_LOCK] = (state_d == ST_LOCK) & ~locked;
    assign evt[IRQ_LOSS] = locked & (state_d != ST_LOCK);

    // apb decode
    logic wr_acc;
    logic setup;
    logic map_hit;
    assign setup   = psel & ~penable;
    assign wr_acc  = psel & penable & pwrite;
    assign map_hit = (paddr == ADDR_CTRL) | (paddr == ADDR_STATUS) | (paddr == ADDR_IRQ_STAT) |
                     (paddr == ADDR_IRQ_MASK) | (paddr == ADDR_PERIOD);
    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;
    assign wr_ctrl = wr_acc & (paddr == ADDR_CTRL);
    assign wr_stat = wr_acc & (paddr == ADDR_IRQ_STAT);
    assign wr_mask = wr_acc & (paddr == ADDR_IRQ_MASK);

    wcs_status_t status;
    assign status = '{spd_class: spd_of(det_q), cur_rate: cur_idx, det_rate: det_q,
                      fallback: fallback_q, sync: slave, lock: locked};

    logic [31:0] rd_mux;
    assign rd_mux = (paddr == ADDR_CTRL)     ? 32'(ctrl_q) :
                    (paddr == ADDR_STATUS)   ? 32'(status) :
                    (paddr == ADDR_IRQ_STAT) ? 32'(irq_stat_q) :
                    (paddr == ADDR_IRQ_MASK) ? 32'(irq_mask_q) :
                    (paddr == ADDR_PERIOD)   ? 32'(per_q) : 32'h0000_0000;

    assign pready        = clk_en;
    assign prdata        = prdata_q;
    assign pslverr       = pslverr_q;
    assign term_en       = ctrl_q.term_en;
    assign ref_lock_lamp = locked;
    assign irq           = |(irq_stat_q & irq_mask_q);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wc_s1_q <= 1'b0;
            wc_s2_q <= 1'b0;
            wc_s3_q <= 1'b0;
        end else if (clk_en) begin
            wc_s1_q <= wc_in;
            wc_s2_q <= wc_s1_q;
            wc_s3_q <= wc_s2_q;
        end
    end

    // period counter, saturates at the loss limit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            per_q <= '0;
        end else if (clk_en) begin
            if (wc_edge) begin
                cnt_q <= PER_W'(1);
                per_q <= cnt_q;
            end else if (!timeout) begin
                cnt_q <= PER_W'(cnt_q + PER_W'(1));
            end
        end
    end

    // candidate class and consecutive match count
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cand_q  <= '0;
            match_q <= '0;
        end else if (clk_en && wc_edge) begin
            cand_q  <= cls_idx;
            match_q <= (same_cls && match_q != LOCK_EDGES) ? 3'(match_q + 3'h1) : 3'h0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            det_q   <= IDX_RESET;
        end else if (clk_en) begin
            state_q <= state_d;
            if (state_d == ST_LOCK) begin
                det_q <= cand_q;
            end
        end
    end

    // fallback master at last detected rate after a slave reference fails
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fallback_q <= 1'b0;
        end else if (clk_en) begin
            if (!ctrl_q.src_word || locked) begin
                fallback_q <= 1'b0;
            end else if (evt[IRQ_LOSS]) begin
                fallback_q <= 1'b1;
            end
            if (slave && evt[IRQ_LOSS]) begin
                fallback_q <= 1'b1;
            end
        end
    end

    // input edge divider for the single speed output alignment
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_q <= '0;
        end else if (clk_en && wc_edge) begin
            div_cnt_q <= (div_cnt_q >= div_max) ? 2'h0 : 2'(div_cnt_q + 2'h1);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q     <= CTRL_RESET;
            irq_mask_q <= '0;
        end else if (clk_en) begin
            if (wr_ctrl) begin
                ctrl_q <= wcs_ctrl_t'(pwdata[$bits(wcs_ctrl_t)-1:0]);
            end
            if (wr_mask) begin
                irq_mask_q <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // sticky events, write one to clear, a new event wins
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= '0;
        end else if (clk_en) begin
            irq_stat_q <= (irq_stat_q & ~(wr_stat ? pwdata[IRQ_W-1:0] : '0)) | evt;
        end
    end

    // read data captured in the setup cycle, presented in the access cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end else if (clk_en && setup) begin
            prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr_q <= ~map_hit;
        end
    end
endmodule // wcs_top
`default_nettype wire

// File: verification/wcs_chk.sv
// word clock sync checker: apb answers, lock lamp timing, output clock activity and phase
// bound to wcs_top; sees only its ports, tracks ctrl and mask writes itself
`default_nettype none
module wcs_chk
    import wcs_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              rst_n,
    input wire logic              clk_en,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              wc_in,
    input wire logic              wc_out,
    input wire logic              hr_clk,
    input wire logic              term_en,
    input wire logic              ref_lock_lamp,
    input wire logic              irq
);
    logic        in_q, src_q, sgl_q, term_q;
    logic [1:0]  msk_q;
    logic [11:0] idle_q, rise_q, oidle_q;
    wire         acc = psel && penable && clk_en;
    wire         wr  = acc && pwrite;
    wire         map = paddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_IRQ_STAT, ADDR_IRQ_MASK, ADDR_PERIOD};

    // input idle counters saturate so a stopped input cannot wrap them; the output idle counter does not saturate
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            {in_q, src_q, sgl_q, term_q, msk_q} <= '0;
            {idle_q, rise_q, oidle_q} <= '0;
        end else begin
            in_q    <= wc_in;
            idle_q  <= (wc_in != in_q) ? 12'h000 : idle_q + 12'(idle_q != 12'hfff);
            rise_q  <= (wc_in && !in_q) ? 12'h000 : rise_q + 12'(rise_q != 12'hfff);
            oidle_q <= ($changed(wc_out) || !clk_en) ? 12'h000 : oidle_q + 12'h001;
            if (wr && paddr == ADDR_CTRL) {term_q, sgl_q, src_q} <= pwdata[2:0];
            if (wr && paddr == ADDR_IRQ_MASK) msk_q <= pwdata[1:0];
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_setup;
        psel && !penable && clk_en ##1 acc;
    endsequence
    sequence s_in_rise;
        src_q && !sgl_q && ref_lock_lamp && wc_in && !in_q;
    endsequence

    property p_err;   s_setup |-> pslverr == !map; endproperty
    property p_wzero; s_setup ##0 pwrite |-> prdata == 32'h0000_0000; endproperty
    property p_term;  term_en == term_q; endproperty
    property p_loss;  idle_q > 12'(LOSS_CYC + 16) |-> !ref_lock_lamp; endproperty
    property p_lock;  $rose(ref_lock_lamp) |-> rise_q < 12'h008; endproperty
    property p_out;   oidle_q < 12'h320; endproperty
    property p_align; s_in_rise |-> ##5 wc_out [*8]; endproperty
    property p_mask;  $stable(msk_q) && msk_q == 2'h0 |-> !irq; endproperty

    a_err:   assert property (p_err) else $error("pslverr disagrees with address decode");
    a_wzero: assert property (p_wzero) else $error("write access returned nonzero read data");
    a_term:  assert property (p_term) else $error("termination enable differs from ctrl");
    a_loss:  assert property (p_loss) else $error("lock lamp still lit after input stopped");
    a_lock:  assert property (p_lock) else $error("lock lamp rose away from an input edge");
    a_out:   assert property (p_out) else $error("word clock output stalled");
    a_align: assert property (p_align) else $error("slave output not in phase with input");
    a_mask:  assert property (p_mask) else $error("interrupt high with all sources masked");
endmodule // wcs_chk

bind wcs_top wcs_chk u_wcs_chk (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wc_in(wc_in), .wc_out(wc_out), .hr_clk(hr_clk), .term_en(term_en),
    .ref_lock_lamp(ref_lock_lamp), .irq(irq));
`default_nettype wire

// File: verification/wcs_src_model.sv
// word clock source model: square wave at a programmed period, rests low when stopped
// driven by the testbench; free of any phase relation to ref_clk
`default_nettype none
module wcs_src_model (
    input  wire logic        run,
    input  wire logic [31:0] per_ps,
    output logic             wc
);
    timeunit 1ns;
    timeprecision 1ps;
    // sends only while told, so the device is the sole master otherwise
    always begin
        wc = 1'b0;
        wait (run === 1'b1);
        while (run === 1'b1) begin
            wc = 1'b1;
            #(real'(per_ps) / 2000.0);
            wc = 1'b0;
            #(real'(per_ps) / 2000.0);
        end
    end
endmodule // wcs_src_model
`default_nettype wire

// File: verification/test_word_clock_sync_unit.sv
// word clock sync testbench: registers, rate detection, slave, fallback, master rates
// drives wcs_top over apb and a word clock source model
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; $display("MISMATCH %s exp %0h seen %0h", n, e, g); end end
module test_word_clock_sync_unit
    import wcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              ref_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, run = 1'b0;
    logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0]       pwdata = '0, per_ps = 32'd20_000_000;
    logic [31:0]       prdata;
    logic              pready, pslverr, wc_in, wc_out, hr_clk, term_en, ref_lock_lamp, irq;
    int                num_errors = 0, checks_done = 0, cyc = 0;

    wcs_top u_wcs_top (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wc_in(wc_in), .wc_out(wc_out), .hr_clk(hr_clk), .term_en(term_en), .ref_lock_lamp(ref_lock_lamp),
        .irq(irq));
    wcs_src_model u_wcs_src_model (.run(run), .per_ps(per_ps), .wc(wc_in));

    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 98000) begin
            num_errors++;
            results();
        end
    end

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // wait states end when pready is high; a pready stuck low ends only on the bench timeout
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] m, input logic [31:0] x, input logic ex,
                      input string n);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        `CHK(n, x, r & m)
        `CHK("pslverr", ex, e)
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic lamp(input logic v, input int lim);
        int n;
        n = 0;
        while (ref_lock_lamp !== v && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK("lamp", v, ref_lock_lamp)
    endtask
    // cycles from the call to the next rising edge of the output
    task automatic rise(output int n);
        n = 1;
        @(negedge ref_clk);
        while (wc_out !== 1'b0 && n < 4000) begin
            @(negedge ref_clk);
            n++;
        end
        while (wc_out !== 1'b1 && n < 4000) begin
            @(negedge ref_clk);
            n++;
        end
    endtask
    task automatic meas(input int x, input string nm);
        int n;
        rise(n);
        rise(n);
        rise(n);
        `CHK(nm, 1'b1, (n >= x - 2 && n <= x + 2))
    endtask
    // rising edges of the high rate clock over 1000 reference cycles
    task automatic hr(input int x);
        logic p;
        int   n;
        p = hr_clk;
        n = 0;
        repeat (1000) begin
            @(negedge ref_clk);
            n += int'(hr_clk === 1'b1 && p === 1'b0);
            p = hr_clk;
        end
        `CHK("hr_clk rises", 1'b1, (n >= x - 2 && n <= x + 2))
    endtask

    task automatic t_regs;
        rd(ADDR_CTRL, 32'hffff_ffff, 32'h0000_0010, 1'b0, "ctrl");
        rd(ADDR_STATUS, 32'h0000_01c7, 32'h0000_0080, 1'b0, "status");
        rd(8'h40, 32'hffff_ffff, 32'h0000_0000, 1'b1, "unmapped");
        wr(ADDR_STATUS, 32'hffff_ffff);
        rd(ADDR_STATUS, 32'h0000_01c7, 32'h0000_0080, 1'b0, "status ro");
        wr(ADDR_CTRL, 32'h0000_0014);
        @(negedge ref_clk);
        `CHK("term_en", 1'b1, term_en)
        wr(ADDR_CTRL, 32'h0000_0010);
        @(negedge ref_clk);
        `CHK("term_en", 1'b0, term_en)
        @(posedge ref_clk);
        clk_en <= 1'b0;
        @(negedge ref_clk);
        `CHK("pready", 1'b0, pready)
        @(posedge ref_clk);
        clk_en <= 1'b1;
        meas(CLK_HZ / RATE_HZ[2], "reset rate");
    endtask
    task automatic t_detect;
        wr(ADDR_IRQ_MASK, 32'h0000_0003);
        for (int i = 0; i < 8; i++) begin
            per_ps <= 32'(64'd1_000_000_000_000 / 64'(RATE_HZ[i]));
            run <= 1'b1;
            if (i > 0) lamp(1'b0, 4000);
            lamp(1'b1, 12000);
            rd(ADDR_STATUS, 32'h0000_063f, {21'h0, 2'(i >= 6 ? 2 : i >= 3 ? 1 : 0), 3'h0, 3'(i), 3'h1}, 1'b0,
               "status");
        end
        `CHK("irq", 1'b1, irq)
        wr(ADDR_IRQ_MASK, 32'h0000_0000);
        repeat (2) @(negedge ref_clk);
        `CHK("irq", 1'b0, irq)
        rd(ADDR_IRQ_STAT, 32'h0000_0003, 32'h0000_0003, 1'b0, "irq_stat");
        wr(ADDR_IRQ_STAT, 32'h0000_0003);
        rd(ADDR_IRQ_STAT, 32'h0000_0003, 32'h0000_0000, 1'b0, "irq_stat");
    endtask
    task automatic t_bad;
        per_ps <= 32'd18_000_000;
        lamp(1'b0, 4000);
        repeat (9000) @(negedge ref_clk);
        lamp(1'b0, 0);
    endtask
    task automatic t_slave;
        per_ps <= 32'(64'd1_000_000_000_000 / 64'(RATE_HZ[5]));
        lamp(1'b1, 8000);
        wr(ADDR_CTRL, 32'h0000_0011);
        rd(ADDR_STATUS, 32'h0000_01c6, 32'h0000_0142, 1'b0, "slave");
        meas(CLK_HZ / RATE_HZ[5], "slave period");
        wr(ADDR_CTRL, 32'h0000_0013);
        meas(CLK_HZ / RATE_HZ[2], "single speed");
        wr(ADDR_CTRL, 32'h0000_0011);
        run <= 1'b0;
        lamp(1'b0, 2500);
        rd(ADDR_STATUS, 32'h0000_01c6, 32'h0000_0144, 1'b0, "fallback");
        meas(CLK_HZ / RATE_HZ[5], "fallback period");
    endtask
    task automatic t_master;
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_CTRL, 32'(i) << 3);
            meas(CLK_HZ / RATE_HZ[i], "master period");
        end
        wr(ADDR_CTRL, 32'h0000_003a);
        meas(CLK_HZ / RATE_HZ[2], "master single");
        hr(RATE_HZ[2] * (1 << HR_SHIFT) / (CLK_HZ / 1000));
    endtask

    task automatic results;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs();
        t_detect();
        t_bad();
        t_slave();
        t_master();
        results();
    end
endmodule // test_word_clock_sync_unit
`default_nettype wire
